//--- include/dcr_pkg.sv
// constants shared by the dsp subsystem configuration register bank
// assumes a 32-bit apb slave clocked by the host port interface clock
package dcr_pkg;
    // register byte offsets
    localparam logic [7:0] BOOT_CONFIGURATION_OFFSET = 8'h18;
    localparam logic [7:0] HOST_PORT_RAM_CONFIGURATION_OFFSET = 8'h1c;
    localparam logic [7:0] MISCELLANEOUS_DEBUG_OFFSET = 8'h20;
    localparam logic [7:0] ENHANCED_HOST_PORT_CONTROL_OFFSET = 8'h24;
    // field positions
    localparam int BOOT_SELECT_LSB = 0;
    localparam int BOOT_SELECT_W = 4;
    localparam int BOOT_POINTER_ONE_LSB = 4;
    localparam int BOOT_POINTER_TWO_LSB = 10;
    localparam int BOOT_POINTER_W = 6;
    localparam int EXCLUSIVE_REGION_SIZE_W = 16;
    localparam int BRANCH_INPUT_LEVEL_BIT = 8;
    localparam int CLOCK_GATING_ENABLE_BIT = 0;
    // reset values
    localparam logic [3:0] BOOT_SELECT_RESET = 4'h0;
    localparam logic [5:0] BOOT_POINTER_RESET = 6'h00;
    localparam logic [15:0] EXCLUSIVE_REGION_SIZE_RESET = 16'hffff;
    localparam logic CLOCK_GATING_ENABLE_RESET = 1'b0;
    // single access ram layout
    localparam int RAM_BLOCK_COUNT = 32;
    localparam int RAM_BLOCK_KBYTES = 2;
    localparam logic [15:0] REGION_SIZE_ALL_BLOCKS = 16'h0040;
endpackage

//--- hw/dcr_region_decode.sv
// decode of the exclusive region size into a reserved-block mask
// assumes a registered size value; purely combinational
module dcr_region_decode
    import dcr_pkg::*;
#(
    parameter int BLOCKS = RAM_BLOCK_COUNT
)
(
    // size in
    input wire logic [EXCLUSIVE_REGION_SIZE_W-1:0] size_i,
    // mask out, bit n set = block n host only
    output logic [BLOCKS-1:0] reserved_o
);
    logic [EXCLUSIVE_REGION_SIZE_W-1:0] blocks_wanted;

    // two size values per block, filling up from block zero
    assign blocks_wanted = size_i >> 1;

    always_comb
    begin
        for (int n = 0; n < BLOCKS; n++)
        begin
            reserved_o[n] = (size_i >= REGION_SIZE_ALL_BLOCKS) || (blocks_wanted > 16'(n));
        end
    end
endmodule

//--- hw/dcr_regs.sv
// dsp subsystem configuration register bank with host port clock gating
// assumes apb master on clock_i; requesters hold requests until serviced
//
// Contract
// RULE_01 - four-bit boot select in bits 3:0 drives dsp boot inputs, resets zero
// RULE_02 - two six-bit boot pointers in bits 15:10 and 9:4, storage only, reset zero
// RULE_03 - sixteen-bit exclusive region size, read/write, resets to all ones
// RULE_04 - sizes zero and one reserve nothing; each two more reserve next block
// RULE_05 - ram is thirty-two 2 KB blocks; reserved ones host only, others shared
// RULE_06 - size 0x0040 or more reserves all thirty-two blocks
// RULE_07 - read-only bit 8 shows branch input level, sampled each cycle, resets zero
// RULE_08 - clock gating enable in control bit 0, cleared at reset
// RULE_09 - with gating enabled, host port clock stops while no request pending; here the registered enable keeps it running one cycle longer
// RULE_10 - gated clock restarts at once on any request, request held until running
// RULE_11 - reserved bits read zero and writes to them have no effect
//
// Register access over APB is this design's own decision.
module dcr_regs
    import dcr_pkg::*;
#(
    parameter int BLOCKS = RAM_BLOCK_COUNT
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // dsp core side
    input wire logic branch_input_signal_i,
    output logic [BOOT_SELECT_W-1:0] boot_select_o,
    output logic [BLOCKS-1:0] host_only_block_o,
    // requesters of the host port
    input wire logic core_request_i,
    input wire logic dsp_dma_request_i,
    input wire logic system_dma_request_i,
    input wire logic on_chip_protocol_initiator_request_i,
    output logic host_port_clock_enable_o
);
    logic [BOOT_SELECT_W-1:0] boot_select_q, boot_select_d;
    logic [BOOT_POINTER_W-1:0] boot_pointer_one_q, boot_pointer_one_d;
    logic [BOOT_POINTER_W-1:0] boot_pointer_two_q, boot_pointer_two_d;
    logic [EXCLUSIVE_REGION_SIZE_W-1:0] exclusive_region_size_q, exclusive_region_size_d;
    logic clock_gating_enable_q, clock_gating_enable_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic branch_meta_q, branch_sync_q, branch_input_level_q;
    logic branch_meta_d, branch_sync_d, branch_input_level_d;
    logic clock_enable_q, clock_enable_d;
    logic [BLOCKS-1:0] reserved_mask;
    logic [BLOCKS-1:0] host_only_q, host_only_d;
    logic setup, wr, mapped, any_request;

    // single-cycle access phase: pready answers in the first access cycle
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_comb
    begin
        case (paddr[7:0])
            BOOT_CONFIGURATION_OFFSET,
            HOST_PORT_RAM_CONFIGURATION_OFFSET,
            MISCELLANEOUS_DEBUG_OFFSET,
            ENHANCED_HOST_PORT_CONTROL_OFFSET: mapped = (paddr[31:8] == 24'h000000);
            default: mapped = 1'b0;
        endcase
    end

    // register writes; only documented fields are stored
    always_comb
    begin
        boot_select_d = boot_select_q;
        boot_pointer_one_d = boot_pointer_one_q;
        boot_pointer_two_d = boot_pointer_two_q;
        exclusive_region_size_d = exclusive_region_size_q;
        clock_gating_enable_d = clock_gating_enable_q;
        if (wr && mapped)
        begin
            case (paddr[7:0])
                BOOT_CONFIGURATION_OFFSET:
                begin
                    boot_select_d = pwdata[BOOT_SELECT_LSB +: BOOT_SELECT_W]; // [RULE_01]
                    boot_pointer_one_d = pwdata[BOOT_POINTER_ONE_LSB +: BOOT_POINTER_W]; // [RULE_02]
                    boot_pointer_two_d = pwdata[BOOT_POINTER_TWO_LSB +: BOOT_POINTER_W]; // [RULE_02]
                end
                HOST_PORT_RAM_CONFIGURATION_OFFSET:
                begin
                    exclusive_region_size_d = pwdata[EXCLUSIVE_REGION_SIZE_W-1:0]; // [RULE_03]
                end
                ENHANCED_HOST_PORT_CONTROL_OFFSET:
                begin
                    clock_gating_enable_d = pwdata[CLOCK_GATING_ENABLE_BIT]; // [RULE_08]
                end
                default:
                begin
                    // miscellaneous register holds nothing writable [RULE_11]
                end
            endcase
        end
    end

    // read data captured in the setup cycle, stands through the access phase
    always_comb
    begin
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (setup)
        begin
            prdata_d = 32'h00000000; // [RULE_11]
            pslverr_d = !mapped;
            case (paddr[7:0])
                BOOT_CONFIGURATION_OFFSET:
                begin
                    prdata_d[BOOT_SELECT_LSB +: BOOT_SELECT_W] = boot_select_q;
                    prdata_d[BOOT_POINTER_ONE_LSB +: BOOT_POINTER_W] = boot_pointer_one_q;
                    prdata_d[BOOT_POINTER_TWO_LSB +: BOOT_POINTER_W] = boot_pointer_two_q;
                end
                HOST_PORT_RAM_CONFIGURATION_OFFSET:
                begin
                    prdata_d[EXCLUSIVE_REGION_SIZE_W-1:0] = exclusive_region_size_q;
                end
                MISCELLANEOUS_DEBUG_OFFSET:
                begin
                    prdata_d[BRANCH_INPUT_LEVEL_BIT] = branch_input_level_q; // [RULE_07]
                end
                ENHANCED_HOST_PORT_CONTROL_OFFSET:
                begin
                    prdata_d[CLOCK_GATING_ENABLE_BIT] = clock_gating_enable_q;
                end
                default:
                begin
                    prdata_d = 32'h00000000;
                end
            endcase
            if (!mapped)
            begin
                prdata_d = 32'h00000000;
            end
        end
    end

    // requests are combined unregistered so a wake never waits a cycle
    assign any_request = core_request_i || dsp_dma_request_i || system_dma_request_i
        || on_chip_protocol_initiator_request_i;

    always_comb
    begin
        clock_enable_d = !clock_gating_enable_q || any_request; // [RULE_09]
    end

    // the registered enable lags; the request term restarts the clock immediately
    assign host_port_clock_enable_o = clock_enable_q || !clock_gating_enable_q || any_request; // [RULE_10]

    dcr_region_decode #(
        .BLOCKS(BLOCKS)
    ) u_region_decode (
        .size_i(exclusive_region_size_q),
        .reserved_o(reserved_mask) // [RULE_04] [RULE_06]
    );

    assign boot_select_o = boot_select_q; // [RULE_01]
    assign host_only_block_o = host_only_q; // [RULE_05]

    // branch input is asynchronous: two stages, then the visible sample
    always_comb
    begin
        branch_meta_d = branch_input_signal_i;
        branch_sync_d = branch_meta_q;
        branch_input_level_d = branch_sync_q; // [RULE_07]
        host_only_d = reserved_mask; // [RULE_05]
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            boot_select_q <= BOOT_SELECT_RESET; // [RULE_01]
            boot_pointer_one_q <= BOOT_POINTER_RESET; // [RULE_02]
            boot_pointer_two_q <= BOOT_POINTER_RESET; // [RULE_02]
            exclusive_region_size_q <= EXCLUSIVE_REGION_SIZE_RESET; // [RULE_03]
            clock_gating_enable_q <= CLOCK_GATING_ENABLE_RESET; // [RULE_08]
        end
        else
        begin
            boot_select_q <= boot_select_d;
            boot_pointer_one_q <= boot_pointer_one_d;
            boot_pointer_two_q <= boot_pointer_two_d;
            exclusive_region_size_q <= exclusive_region_size_d;
            clock_gating_enable_q <= clock_gating_enable_d;
        end
    end

    // bus response kept apart from the configuration state it reports
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // stages reset low so the bit reads zero until the pin has been seen
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            branch_meta_q <= 1'b0;
            branch_sync_q <= 1'b0;
            branch_input_level_q <= 1'b0;
        end
        else
        begin
            branch_meta_q <= branch_meta_d;
            branch_sync_q <= branch_sync_d;
            branch_input_level_q <= branch_input_level_d;
        end
    end

    // enable resets high: the host port runs until software opts in to gating
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            clock_enable_q <= 1'b1;
            host_only_q <= {BLOCKS{1'b1}};
        end
        else
        begin
            clock_enable_q <= clock_enable_d;
            host_only_q <= host_only_d;
        end
    end
endmodule

//--- tb/dcr_regs_monitor.sv
// assertions on the ports of the configuration register bank
// assumes binding into dcr_regs; gating enable is shadowed from apb writes
module dcr_regs_monitor
    import dcr_pkg::*;
#(
    parameter int BLOCKS = RAM_BLOCK_COUNT
)
(
    // clock, reset and apb
    input wire logic clock_i, reset_i, psel, penable, pwrite,
    input wire logic [31:0] paddr, pwdata, prdata,
    input wire logic pready, pslverr,
    // dsp side and requesters
    input wire logic branch_input_signal_i,
    input wire logic [BOOT_SELECT_W-1:0] boot_select_o,
    input wire logic [BLOCKS-1:0] host_only_block_o,
    input wire logic core_request_i, dsp_dma_request_i, system_dma_request_i,
    input wire logic on_chip_protocol_initiator_request_i, host_port_clock_enable_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic gate_q;
    logic gate_d;
    logic wr;
    logic [3:0] req;
    assign wr = psel && penable && pwrite;
    assign req = {core_request_i, dsp_dma_request_i, system_dma_request_i, on_chip_protocol_initiator_request_i};
    // the enable is internal, so it is rebuilt from the bus
    always_comb gate_d = (wr && paddr == 32'h24) ? pwdata[0] : gate_q;
    always_ff @(posedge clock_i) gate_q <= reset_i ? 1'b0 : gate_d;
    function automatic logic [BLOCKS-1:0] mask_of(input logic [15:0] s);
        return (s >= 16'h0040) ? '1 : BLOCKS'((64'h1 << s[15:1]) - 64'h1);
    endfunction
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    a_reset_state: assert property ($fell(reset_i) |-> boot_select_o == 4'h0 && host_only_block_o == '1)
        else $error("state after reset wrong");
    a_boot_follow: assert property (wr && paddr == 32'h18 |=> boot_select_o == $past(pwdata[3:0]))
        else $error("boot select not updated");
    a_region_map: assert property (wr && paddr == 32'h1c |=> ##1 host_only_block_o == mask_of($past(pwdata[15:0], 2)))
        else $error("reserved block mask wrong");
    a_gate_idle: assert property (!gate_q |-> host_port_clock_enable_o)
        else $error("clock stopped with gating off");
    a_gate_stop: assert property (gate_q && $past(gate_q) && req == 4'h0 && $past(req) == 4'h0 |-> !host_port_clock_enable_o)
        else $error("clock runs with no request");
    a_gate_wake: assert property (req != 4'h0 |-> host_port_clock_enable_o)
        else $error("clock stopped during request");
    a_misc_zero: assert property (psel && penable && !pwrite && paddr == 32'h20 |-> prdata[31:9] == 23'h0 && prdata[7:0] == 8'h0)
        else $error("reserved bits not zero");
    a_error_flag: assert property (psel && penable |-> pready && pslverr == !(paddr inside {32'h18, 32'h1c, 32'h20, 32'h24}))
        else $error("bus response wrong");
endmodule
bind dcr_regs dcr_regs_monitor #(.BLOCKS(BLOCKS)) u_monitor (.clock_i, .reset_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .branch_input_signal_i, .boot_select_o, .host_only_block_o, .core_request_i,
    .dsp_dma_request_i, .system_dma_request_i, .on_chip_protocol_initiator_request_i, .host_port_clock_enable_o);

//--- tb/dcr_requesters.sv
// model of the host port requesters: core, two dma engines, protocol initiator
// assumes the bank's clock; a request stays up until the gated clock runs
module dcr_requesters
(
    input wire logic clock_i, reset_i, clk_en_i,
    input wire logic [3:0] want_i,
    output logic [3:0] req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] req_q;
    logic [3:0] req_d;
    // dropping before the clock runs would lose the access
    always_comb req_d = want_i | (req_q & {4{~clk_en_i}});
    always_ff @(posedge clock_i) req_q <= reset_i ? 4'h0 : req_d;
    assign req_o = req_q;
endmodule

//--- tb/dcr_regs_tb.sv
// bench for the configuration register bank: apb master, requester model, checks
// assumes pready comes in the access phase and outputs settle after each edge
module dcr_regs_tb
    import dcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, branch = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, blocks, m;
    logic pready, pslverr, err, clk_en;
    logic [3:0] want = 4'h0, req, boot_sel;
    int fail_count = 0, n_compared = 0, cycles = 0;
    dcr_regs dut (.clock_i, .reset_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .branch_input_signal_i(branch), .boot_select_o(boot_sel), .host_only_block_o(blocks), .core_request_i(req[3]),
        .dsp_dma_request_i(req[2]), .system_dma_request_i(req[1]), .on_chip_protocol_initiator_request_i(req[0]),
        .host_port_clock_enable_o(clk_en));
    dcr_requesters partner (.clock_i, .reset_i, .clk_en_i(clk_en), .want_i(want), .req_o(req));
    initial forever #25 clock_i = ~clock_i;
    always @(posedge clock_i)
        if (cycles++ == 4000)
            conclude(1);
    task automatic conclude(input int extra);
        fail_count += extra;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
            $display("BAD %s expected %h seen %h count %0d", name, exp, seen, ++fail_count);
    endtask
    // read data and error are taken at the rising edge where pready is seen high;
    // the request stays up until the caller changes it; a wait ends when pready is seen high, or at the timeout
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clock_i);
        penable <= 1'b1;
        do
            @(posedge clock_i);
        while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
    endtask
    task automatic idle();
        {psel, penable} <= 2'b00;
        @(posedge clock_i);
    endtask
    task automatic expect_rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        idle();
        check("prdata", rd, exp);
    endtask
    task automatic t_reset();
        expect_rd(32'h18, 32'h0);
        expect_rd(32'h1c, 32'hffff);
        expect_rd(32'h20, 32'h0);
        expect_rd(32'h24, 32'h0);
        check("blocks", blocks, 32'hffffffff);
        $display("reset test done");
    endtask
    task automatic t_boot();
        apb(1'b1, 32'h18, 32'hffffffff);
        expect_rd(32'h18, 32'hffff);
        check("boot_sel", {28'h0, boot_sel}, 32'hf);
        apb(1'b1, 32'h18, 32'ha5a6);
        expect_rd(32'h18, 32'ha5a6);
        check("boot_sel", {28'h0, boot_sel}, 32'h6);
        $display("boot test done");
    endtask
    task automatic t_region();
        logic [15:0] sz [9] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h11, 16'h3e, 16'h3f, 16'h40, 16'h8001};
        foreach (sz[i])
        begin
            apb(1'b1, 32'h1c, {16'hffff, sz[i]});
            expect_rd(32'h1c, {16'h0, sz[i]});
            m = (sz[i] >= 16'h40) ? 32'hffffffff : (32'h1 << sz[i][15:1]) - 32'h1;
            check("blocks", blocks, m);
        end
        $display("region test done");
    endtask
    task automatic t_misc();
        branch <= 1'b1;
        repeat (4) @(posedge clock_i);
        expect_rd(32'h20, 32'h100);
        apb(1'b1, 32'h20, 32'hfffffeff);
        expect_rd(32'h20, 32'h100);
        branch <= 1'b0;
        repeat (4) @(posedge clock_i);
        expect_rd(32'h20, 32'h0);
        expect_rd(32'h28, 32'h0);
        check("pslverr", {31'h0, err}, 32'h1);
        $display("misc test done");
    endtask
    task automatic t_gate();
        apb(1'b1, 32'h24, 32'hffffffff);
        expect_rd(32'h24, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            want <= 4'h1 << i;
            @(negedge clock_i);
            check("clk_en", {31'h0, clk_en}, 32'h0);
            @(posedge clock_i);
            want <= 4'h0;
            @(negedge clock_i);
            check("clk_en", {31'h0, clk_en}, 32'h1);
            repeat (4) @(posedge clock_i);
        end
        apb(1'b1, 32'h24, 32'h0);
        idle();
        check("clk_en", {31'h0, clk_en}, 32'h1);
        $display("gate test done");
    endtask
    initial
    begin
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        t_reset();
        t_boot();
        t_region();
        t_misc();
        t_gate();
        conclude(0);
    end
endmodule
